// File: sar_sequencer.sv
`timescale 1ns/1ps
module sar_sequencer
  import sar_seq_pkg::*;
(
  // clock and reset
  input  wire logic                                     MCLK,
  input  wire logic                                     ARST_N,
  // host pins
  input  wire logic                                     START,
  input  wire logic                                     ALE,
  input  wire logic                                     OE,
  input  wire logic [sar_seq_pkg::CHAN_BITS-1:0]        CHANNEL_SELECT,
  // analog front end
  input  wire logic                                     COMP_HIGH,
  output logic      [sar_seq_pkg::NUM_CHANNELS-1:0]     MUX_ENABLE,
  output logic                                          ACQUIRE,
  output logic                                          AUTO_ZERO,
  output logic      [sar_seq_pkg::RESULT_BITS-1:0]      DAC_CODE,
  // result bus and status
  output logic      [sar_seq_pkg::RESULT_BITS-1:0]      RESULT_BUS_O,
  output logic      [sar_seq_pkg::RESULT_BITS-1:0]      RESULT_BUS_OE,
  output logic                                          EOC
);

  import sar_seq_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pins_t pins_raw;
  pins_t meta_q;
  pins_t sync_q;
  logic  ale_prev_q;
  logic  start_prev_q;

  assign pins_raw = '{start:          START,
                      ale:            ALE,
                      oe:             OE,
                      comp_high:      COMP_HIGH,
                      channel_select: CHANNEL_SELECT};

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_q       <= '0;
      sync_q       <= '0;
      ale_prev_q   <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      meta_q       <= pins_raw;
      sync_q       <= meta_q;
      ale_prev_q   <= sync_q.ale;
      start_prev_q <= sync_q.start;
    end
  end

  logic ale_rise;
  logic start_fall;

  assign ale_rise   = sync_q.ale & ~ale_prev_q;
  assign start_fall = ~sync_q.start & start_prev_q;

  // ----------------------------------------------------------------
  // channel latch and decoder
  // ----------------------------------------------------------------
  function automatic logic [NUM_CHANNELS-1:0] decode_channel(
    input logic [CHAN_BITS-1:0] sel
  );
    logic [NUM_CHANNELS-1:0] onehot;
    onehot      = '0;
    onehot[sel] = 1'b1;
    return onehot;
  endfunction

  logic [CHAN_BITS-1:0]    chan_q;
  logic [CHAN_BITS-1:0]    chan_d;
  logic [NUM_CHANNELS-1:0] mux_q;
  logic [NUM_CHANNELS-1:0] mux_d;

  always_comb begin
    chan_d = chan_q;
    if (ale_rise) begin
      chan_d = sync_q.channel_select;
    end
    mux_d = decode_channel(chan_d);
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      chan_q <= CHAN_RST;
      mux_q  <= '0;
    end else begin
      chan_q <= chan_d;
      mux_q  <= mux_d;
    end
  end

  // ----------------------------------------------------------------
  // phase decode helpers
  // ----------------------------------------------------------------
  // true while cnt lies in [lo, hi)
  function automatic logic in_span(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lo,
    input logic [CNT_W-1:0] hi
  );
    return (cnt >= lo) && (cnt < hi);
  endfunction

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  seq_state_t             state_q;
  seq_state_t             state_d;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic                   acq_q;
  logic                   acq_d;
  logic                   az_q;
  logic                   az_d;
  logic                   restart;
  logic                   launch;
  logic                   running;
  logic                   conv_begin;
  logic                   conv_done;
  logic                   converting;

  // a start pulse at any point aborts and clears the sequence
  assign restart    = sync_q.start && (state_q != ST_HOLD);
  assign launch     = (state_q == ST_HOLD) && start_fall;
  assign running    = (state_q == ST_RUN) && !sync_q.start;
  assign conv_begin = running && (cnt_q == EDGE_CONV_BEGIN - 7'h01);
  assign conv_done  = running && (cnt_q == EDGE_DONE - 7'h01);
  assign converting = running && in_span(cnt_q, EDGE_CONV_BEGIN, EDGE_CONV_END);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    acq_d   = 1'b0;
    az_d    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (restart) begin
          state_d = ST_HOLD;
          cnt_d   = '0;
        end
      end
      ST_RUN: begin
        if (restart) begin
          state_d = ST_HOLD;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 7'h01;
          az_d  = in_span(cnt_d, EDGE_AZ_BEGIN, EDGE_ACQ_BEGIN);
          acq_d = in_span(cnt_d, EDGE_ACQ_BEGIN, EDGE_CONV_BEGIN);
          if (conv_done) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (launch) begin
          // first edge after start falls is edge one (late release slips one clock)
          state_d = ST_RUN;
          cnt_d   = EDGE_AZ_BEGIN;
          az_d    = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      acq_q   <= 1'b0;
      az_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      acq_q   <= acq_d;
      az_q    <= az_d;
    end
  end

  // ----------------------------------------------------------------
  // bit step timer, one decision per seven clocks
  // ----------------------------------------------------------------
  logic [2:0]             step_q;
  logic [2:0]             step_d;
  logic                   sar_clear;
  logic                   sar_decide;

  always_comb begin
    step_d     = step_q;
    sar_clear  = restart || (state_q == ST_HOLD);
    sar_decide = 1'b0;
    if (restart || conv_begin) begin
      step_d = '0;
    end else if (converting) begin
      if (step_q == BIT_CLOCKS - 3'h1) begin
        sar_decide = 1'b1;
        step_d     = '0;
      end else begin
        step_d = step_q + 3'h1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      step_q <= '0;
    end else begin
      step_q <= step_d;
    end
  end

  // ----------------------------------------------------------------
  // done flag and double-buffered result
  // ----------------------------------------------------------------
  logic                   eoc_q;
  logic                   eoc_d;
  logic [RESULT_BITS-1:0] result_q;
  logic [RESULT_BITS-1:0] result_d;
  logic [RESULT_BITS-1:0] sar_trial;
  logic [RESULT_BITS-1:0] sar_result;

  // an abort touches neither: the old word stays valid
  always_comb begin
    eoc_d    = eoc_q;
    result_d = result_q;
    if (conv_begin) begin
      eoc_d = 1'b0;
    end
    if (conv_done) begin
      result_d = sar_result;
      eoc_d    = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      eoc_q    <= DONE_RST;
      result_q <= RESULT_RST;
    end else begin
      eoc_q    <= eoc_d;
      result_q <= result_d;
    end
  end

  sar_register #(
    .WIDTH      (RESULT_BITS)
  ) u_sar (
    .clk        (MCLK),
    .arst_n     (ARST_N),
    .clear      (sar_clear),
    .decide     (sar_decide),
    .comp_high  (sync_q.comp_high),
    .trial_code (sar_trial),
    .result     (sar_result)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  bus_out_t bus_q;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_q <= '0;
    end else begin
      bus_q.drive <= sync_q.oe;
      bus_q.data  <= result_d;
    end
  end

  assign RESULT_BUS_O  = bus_q.data;
  assign RESULT_BUS_OE = {RESULT_BITS{bus_q.drive}};
  assign EOC           = eoc_q;
  assign MUX_ENABLE    = mux_q;
  assign ACQUIRE       = acq_q;
  assign AUTO_ZERO     = az_q;
  assign DAC_CODE      = sar_trial;

endmodule

// File: sar_seq_pkg.sv
package sar_seq_pkg;

  // ----------------------------------------------------------------
  // sequence timing, in converter clock edges after start falls
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W          = 7;
  localparam int unsigned RESULT_BITS    = 8;
  localparam int unsigned CHAN_BITS      = 3;
  localparam int unsigned NUM_CHANNELS   = 8;
  localparam logic [CNT_W-1:0] EDGE_AZ_BEGIN   = 7'h01;
  localparam logic [CNT_W-1:0] EDGE_ACQ_BEGIN  = 7'h04;
  localparam logic [CNT_W-1:0] EDGE_CONV_BEGIN = 7'h08;
  localparam logic [CNT_W-1:0] EDGE_CONV_END   = 7'h40;
  localparam logic [CNT_W-1:0] EDGE_DONE       = 7'h43;
  localparam logic [2:0]       BIT_CLOCKS      = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 8'h00;
  localparam logic [RESULT_BITS-1:0] MASK_RST   = 8'h80;
  localparam logic [CHAN_BITS-1:0]   CHAN_RST   = 3'h0;
  localparam logic                   DONE_RST   = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic                 start;
    logic                 ale;
    logic                 oe;
    logic                 comp_high;
    logic [CHAN_BITS-1:0] channel_select;
  } pins_t;

  typedef struct packed {
    logic                   drive;
    logic [RESULT_BITS-1:0] data;
  } bus_out_t;

endpackage

// File: sar_register.sv
`timescale 1ns/1ps
module sar_register
  import sar_seq_pkg::*;
#(
  parameter int unsigned WIDTH = RESULT_BITS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // control
  input  wire logic             clear,
  input  wire logic             decide,
  input  wire logic             comp_high,
  // code
  output logic      [WIDTH-1:0] trial_code,
  output logic      [WIDTH-1:0] result
);

  logic [WIDTH-1:0] sar_q;
  logic [WIDTH-1:0] sar_d;
  logic [WIDTH-1:0] mask_q;
  logic [WIDTH-1:0] mask_d;

  // ----------------------------------------------------------------
  // one decision per step, msb first
  // ----------------------------------------------------------------
  always_comb begin
    sar_d  = sar_q;
    mask_d = mask_q;
    if (clear) begin
      sar_d  = RESULT_RST;
      mask_d = MASK_RST;
    end else if (decide && (mask_q != '0)) begin
      if (comp_high) begin
        sar_d = sar_q | mask_q;
      end
      mask_d = mask_q >> 1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar_q  <= RESULT_RST;
      mask_q <= MASK_RST;
    end else begin
      sar_q  <= sar_d;
      mask_q <= mask_d;
    end
  end

  // input below the bottom reference never trips: code stays zero
  assign trial_code = sar_q | mask_q;
  assign result     = sar_q;

endmodule

// File: sar_sequencer_asserts.sv
`timescale 1ns/1ps
module sar_sequencer_asserts
  import sar_seq_pkg::*;
(
  // clock and reset
  input wire logic                                 MCLK,
  input wire logic                                 ARST_N,
  // host and analog pins
  input wire logic                                 START,
  input wire logic                                 ALE,
  input wire logic                                 OE,
  input wire logic [sar_seq_pkg::CHAN_BITS-1:0]    CHANNEL_SELECT,
  input wire logic                                 COMP_HIGH,
  input wire logic [sar_seq_pkg::NUM_CHANNELS-1:0] MUX_ENABLE,
  input wire logic                                 ACQUIRE,
  input wire logic                                 AUTO_ZERO,
  input wire logic [sar_seq_pkg::RESULT_BITS-1:0]  DAC_CODE,
  // result and status
  input wire logic [sar_seq_pkg::RESULT_BITS-1:0]  RESULT_BUS_O,
  input wire logic [sar_seq_pkg::RESULT_BITS-1:0]  RESULT_BUS_OE,
  input wire logic                                 EOC
);
  // -----------------------------------------------
  // cycles since acquisition ended
  // -----------------------------------------------
  logic       acq_q;
  logic [6:0] gap_q;
  logic [6:0] gap_d;
  always_comb begin
    gap_d = gap_q;
    if (acq_q && !ACQUIRE) begin
      gap_d = 7'h01;
    end else if (gap_q != 7'h00 && gap_q != 7'h7F) begin
      gap_d = gap_q + 7'h01;
    end
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acq_q <= 1'b0;
      gap_q <= 7'h00;
    end else begin
      acq_q <= ACQUIRE;
      gap_q <= gap_d;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // -----------------------------------------------
  // checks
  // -----------------------------------------------
  chk_az_before_acq: assert property ($rose(ACQUIRE) |-> $fell(AUTO_ZERO))
    else $error("acquire not after auto-zero");
  chk_acq_four: assert property ($rose(ACQUIRE) |-> ACQUIRE[*4] ##1 (!ACQUIRE && !EOC))
    else $error("acquire length wrong");
  chk_done_gap: assert property ($rose(EOC) |-> gap_q == 7'h3B)
    else $error("done not 59 cycles after edge 8");
  chk_bus_hold: assert property (!$stable(RESULT_BUS_O) |-> $rose(EOC))
    else $error("result changed outside done");
  chk_oe_follow: assert property (RESULT_BUS_OE == {8{$past(OE, 3)}})
    else $error("bus drive not following enable");
  chk_mux_pick: assert property ($rose(ALE) |-> ##4 MUX_ENABLE == (8'h01 << CHANNEL_SELECT))
    else $error("wrong channel enabled");
  chk_mux_hold: assert property (!$stable(MUX_ENABLE) && $past(ARST_N, 2) |->
    $past(ALE, 3) && !$past(ALE, 4))
    else $error("channel changed without strobe");
  chk_msb_first: assert property ($fell(EOC) ##0 (!START)[*7] |->
    DAC_CODE == 8'h80 ##1 DAC_CODE[6:0] == 7'h40)
    else $error("first trial not msb");
  chk_start_clear: assert property (START[*3] |->
    ##2 (DAC_CODE == 8'h80 && !ACQUIRE))
    else $error("start did not clear");
  cover property ($rose(EOC));
  cover property ($rose(ALE) ##3 $changed(MUX_ENABLE));
  cover property (START && !EOC);
endmodule

bind sar_sequencer sar_sequencer_asserts sar_sequencer_asserts_i (
  .MCLK(MCLK), .ARST_N(ARST_N), .START(START), .ALE(ALE), .OE(OE),
  .CHANNEL_SELECT(CHANNEL_SELECT), .COMP_HIGH(COMP_HIGH), .MUX_ENABLE(MUX_ENABLE),
  .ACQUIRE(ACQUIRE), .AUTO_ZERO(AUTO_ZERO), .DAC_CODE(DAC_CODE),
  .RESULT_BUS_O(RESULT_BUS_O), .RESULT_BUS_OE(RESULT_BUS_OE), .EOC(EOC)
);

// File: sar_host_model.sv
`timescale 1ns/1ps
module sar_host_model
  import sar_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] mux_enable,
  input  wire logic [7:0] dac_code,
  output logic            start,
  output logic            ale,
  output logic            oe,
  output logic [2:0]      chan,
  output logic            comp_high
);
  logic [7:0] level [8];
  initial begin
    start = 1'b0;
    ale = 1'b0;
    oe = 1'b0;
    chan = 3'h0;
  end
  // comparator on the enabled input only
  always_comb begin
    comp_high = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (mux_enable[i]) comp_high = (level[i] >= dac_code);
    end
  end
  task automatic pick(input logic [2:0] ch);
    @(posedge clk);
    #1 chan = ch;
    ale = 1'b1;
    repeat (2) @(posedge clk);
    #1 ale = 1'b0;
    repeat (4) @(posedge clk);
    #1 chan = ~ch;
  endtask
  // start released just after an edge, far ahead of setup
  task automatic launch();
    @(posedge clk);
    #1 start = 1'b1;
    repeat (3) @(posedge clk);
    #1 start = 1'b0;
  endtask
  task automatic drive_bus(input logic en);
    @(posedge clk);
    #1 oe = en;
  endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sar_seq_pkg::*;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       start, ale, oe, comp_high, acq, az, eoc;
  logic [2:0] chan;
  logic [7:0] mux, dac, res_o, res_oe;
  int         bad_count = 0;
  int         checked = 0;
  always #20 mclk = ~mclk;
  sar_host_model sar_host_model_i (.clk(mclk), .mux_enable(mux), .dac_code(dac),
    .start(start), .ale(ale), .oe(oe), .chan(chan), .comp_high(comp_high));
  sar_sequencer sar_sequencer_i (.MCLK(mclk), .ARST_N(arst_n), .START(start), .ALE(ale),
    .OE(oe), .CHANNEL_SELECT(chan), .COMP_HIGH(comp_high), .MUX_ENABLE(mux),
    .ACQUIRE(acq), .AUTO_ZERO(az), .DAC_CODE(dac), .RESULT_BUS_O(res_o),
    .RESULT_BUS_OE(res_oe), .EOC(eoc));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // -----------------------------------------------
  // one conversion, optionally restarted at edge ab
  // -----------------------------------------------
  task automatic run_conv(input logic [2:0] ch, input logic [7:0] lvl, input int ab);
    logic [7:0] prev;
    prev = res_o;
    for (int i = 0; i < 8; i++) sar_host_model_i.level[i] = ~lvl;
    if (ab == 0) sar_host_model_i.level[ch] = lvl;
    sar_host_model_i.pick(ch);
    sar_host_model_i.launch();
    for (int k = 1; k <= 69; k++) begin
      @(posedge mclk);
      #1;
      if (k == ab) begin
        sar_host_model_i.level[ch] = lvl;
        sar_host_model_i.launch();
        chk(dac, 8'h80);
        chk(eoc, 1'b0);
        k = 0;
        ab = -1;
      end
      if (k == 1) chk(mux, 8'h01 << ch);
      if (k == 2) chk(az, 1'b0);
      if (k == 3) chk(az, 1'b1);
      if (k == 6) chk({az, acq}, 2'b01);
      if (k == 9) chk(acq, 1'b1);
      if (k == 9 && ab == 0) chk(eoc, 1'b1);
      if (k == 10) chk({acq, eoc}, 2'b00);
      if (k == 68) chk({eoc, res_o}, {1'b0, prev});
      if (k == 69) chk({eoc, res_o}, {1'b1, lvl});
    end
  endtask
  task automatic run_oe();
    sar_host_model_i.drive_bus(1'b1);
    repeat (2) @(posedge mclk);
    #1 chk(res_oe, 8'h00);
    @(posedge mclk);
    #1 chk(res_oe, 8'hFF);
    sar_host_model_i.drive_bus(1'b0);
    repeat (3) @(posedge mclk);
    #1 chk(res_oe, 8'h00);
  endtask
  task automatic run_reset();
    repeat (4) @(posedge mclk);
    #1 chk({eoc, res_oe}, {1'b1, 8'h00});
    arst_n = 1'b1;
    @(posedge mclk);
    #1 chk({eoc, dac}, {1'b1, 8'h80});
  endtask
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] lv [8];
    lv = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h01, 8'h80, 8'h7F, 8'hC3};
    run_reset();
    run_conv(3'h0, lv[0], 0);
    run_oe();
    for (int c = 1; c < 8; c++) run_conv(3'(c), lv[c], 0);
    run_conv(3'h2, 8'h3C, 40);
    run_conv(3'h5, 8'hE7, 7);
    tally_and_finish();
  end
endmodule
